// ### design/uib_pkg.sv
package uib_pkg;
    // Target addressing
    localparam logic [6:0] DEFAULT_ADDR   = 7'h22;
    localparam logic [6:0] GC_ADDR        = 7'h00;
    // Command bytes carried after the general call address
    localparam logic [7:0] CMD_DATA_AVAIL = 8'h0C;
    localparam logic [7:0] CMD_FLUSH      = 8'h0E;
    localparam logic [7:0] CMD_NV_ADDR    = 8'h10;
    localparam logic [7:0] CMD_NV_WRITE   = 8'h12;
    localparam logic [7:0] CMD_NV_READ    = 8'h14;
    // Byte returned when the buffer is read while empty
    localparam logic [7:0] EMPTY_FILL     = 8'h00;
    // Host-to-link buffer
    localparam int         BUF_DEPTH      = 16;
    localparam int         BUF_AW         = 4;
    localparam logic [4:0] BUF_FULL       = 5'h10;
    localparam logic [4:0] CNT_RST        = 5'h00;
    // Bit counting within a byte plus its acknowledge slot
    localparam logic [3:0] BIT_LAST       = 4'h8;
    localparam logic [3:0] BIT_DATA_LAST  = 4'h7;
    // Serial clock timing of the controller end
    localparam int         MCLK_NS        = 100;
    localparam int         SCL_QTR_NS     = 2500;
    localparam int         SCL_QTR_CYC    = (SCL_QTR_NS / MCLK_NS < 1) ? 1
                                            : SCL_QTR_NS / MCLK_NS;
    localparam logic [7:0] QTR_LAST       = 8'(SCL_QTR_CYC - 1);

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_ADDR = 3'h1,
        D_AACK = 3'h2,
        D_WR   = 3'h3,
        D_WACK = 3'h4,
        D_RD   = 3'h5,
        D_RACK = 3'h6
    } uib_dstate_e;

    typedef enum logic [1:0] {
        C_IDLE  = 2'h0,
        C_START = 2'h1,
        C_BITS  = 2'h2,
        C_STOP  = 2'h3
    } uib_cstate_e;
endpackage

// ### design/uib_link_if.sv
`timescale 1ns/1ps
interface uib_link_if (input wire logic link_clk);
    // Open-drain drivers of both ends
    logic ctl_scl_o;
    logic ctl_scl_oe;
    logic ctl_sda_o;
    logic ctl_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    // Resolved wire levels with pull-ups
    logic scl;
    logic sda;

    assign scl = (ctl_scl_oe & ~ctl_scl_o) ? 1'b0 : 1'b1;
    assign sda = ((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o))
                 ? 1'b0 : 1'b1;

    modport device (
        input  link_clk,
        input  scl,
        input  sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport controller (
        input  scl,
        input  sda,
        output ctl_scl_o,
        output ctl_scl_oe,
        output ctl_sda_o,
        output ctl_sda_oe
    );
endinterface

// ### design/uib_dev_end.sv
// What this block does
// - Count command makes next read return buffer count
// - Host bytes buffered until controller reads them
// - Own-address read delivers oldest buffered byte
// - Own-address written bytes forwarded toward host
// - Default seven-bit target address is 0x22
// - Commands travel as writes to general call
// - Payload uses own address, never general call
// - Controller queries count with repeated start
// - Controller reads data only when count nonzero
// - Multi-byte reads return consecutive buffered bytes
// - Whole target protocol handled in hardware
// - Nonvolatile commands served only while awake
// - Low keep-awake pin prevents suspend
// - Flush command discards buffer contents
// - Target never sends data unrequested
`timescale 1ns/1ps
module uib_dev_end #(
    parameter logic [6:0] OWN_ADDR = uib_pkg::DEFAULT_ADDR
) (
    // Link side
    uib_link_if.device link,
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Bytes from the host
    input  wire logic [7:0] usb_rx_data,
    input  wire logic       usb_rx_valid,
    output logic            usb_rx_ready,
    // Bytes toward the host
    output logic [7:0]      usb_tx_data,
    output logic            usb_tx_valid,
    // Power state
    input  wire logic       usb_attached,
    input  wire logic       keep_awake_n,
    output logic            suspended
);
    import uib_pkg::*;

    // Link-domain state
    uib_dstate_e            state_reg;
    uib_dstate_e            state_next;
    logic [7:0]             shift_reg;
    logic [7:0]             shift_next;
    logic [3:0]             bit_reg;
    logic [3:0]             bit_next;
    logic                   rw_reg;
    logic                   rw_next;
    logic                   gc_reg;
    logic                   gc_next;
    logic                   pend_reg;
    logic                   pend_next;
    logic                   oe_reg;
    logic                   oe_next;
    logic                   pop;
    logic                   flush;
    logic                   fwd;
    logic                   load;
    logic [4:0]             s1_reg;
    logic [4:0]             s2_reg;
    logic [2:0]             prev_reg;
    logic                   rx_ack_reg;
    logic                   tx_tog_reg;
    logic [7:0]             tx_data_reg;
    logic [7:0]             mem [BUF_DEPTH];
    logic [BUF_AW-1:0]      wp_reg;
    logic [BUF_AW-1:0]      rp_reg;
    logic [4:0]             cnt_reg;
    // Host-domain state
    logic                   rx_req_reg;
    logic [7:0]             rx_data_reg;
    logic                   rx_ready_reg;
    logic [2:0]             m1_reg;
    logic [2:0]             m2_reg;
    logic                   m_prev_reg;
    logic                   tx_valid_reg;
    logic [7:0]             tx_out_reg;
    logic                   susp_reg;

    // Synchronised link inputs and bus conditions
    wire scl_s      = s2_reg[4];
    wire sda_s      = s2_reg[3];
    wire req_s      = s2_reg[2];
    wire awake      = s2_reg[1] | ~s2_reg[0];
    wire scl_rise   = scl_s & ~prev_reg[2];
    wire scl_fall   = ~scl_s & prev_reg[2];
    wire start_det  = scl_s & prev_reg[2] & prev_reg[1] & ~sda_s;
    wire stop_det   = scl_s & prev_reg[2] & ~prev_reg[1] & sda_s;

    // Address and command decode
    wire gc_hit     = (shift_reg[7:1] == GC_ADDR) & ~shift_reg[0];
    wire own_hit    = shift_reg[7:1] == OWN_ADDR;
    wire addr_hit   = own_hit | gc_hit;
    wire cmd_is_nv  = (shift_reg == CMD_NV_ADDR)
                    | (shift_reg == CMD_NV_WRITE)
                    | (shift_reg == CMD_NV_READ);
    wire byte_ok    = ~gc_reg | ~cmd_is_nv | awake;

    // Buffer status and read data selection
    wire            buf_empty = cnt_reg == CNT_RST;
    wire            buf_full  = cnt_reg == BUF_FULL;
    wire [7:0]      rd_byte   = pend_reg ? {3'h0, cnt_reg}
                              : (buf_empty ? EMPTY_FILL : mem[rp_reg]);
    wire            push      = (req_s != rx_ack_reg) & (~buf_full | pop);
    wire [BUF_AW-1:0] wp_w    = flush ? '0 : wp_reg;

    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = oe_reg;
    assign usb_rx_ready    = rx_ready_reg;
    assign usb_tx_valid    = tx_valid_reg;
    assign usb_tx_data     = tx_out_reg;
    assign suspended       = susp_reg;

    // Target protocol engine
    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        bit_next   = bit_reg;
        rw_next    = rw_reg;
        gc_next    = gc_reg;
        pend_next  = pend_reg;
        oe_next    = oe_reg;
        pop        = 1'b0;
        flush      = 1'b0;
        fwd        = 1'b0;
        load       = 1'b0;
        if (stop_det)
        begin
            state_next = D_IDLE;
            oe_next    = 1'b0;
        end
        else if (start_det)
        begin
            state_next = D_ADDR;
            bit_next   = 4'h0;
            oe_next    = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                D_IDLE: ;
                D_ADDR:
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_next   = bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == BIT_LAST)
                    begin
                        if (addr_hit)
                        begin
                            oe_next    = 1'b1;
                            rw_next    = shift_reg[0];
                            gc_next    = gc_hit;
                            state_next = D_AACK;
                        end
                        else
                            state_next = D_IDLE;
                    end
                D_AACK:
                    if (scl_fall)
                    begin
                        if (rw_reg)
                            load = 1'b1;
                        else
                        begin
                            oe_next    = 1'b0;
                            bit_next   = 4'h0;
                            state_next = D_WR;
                        end
                    end
                D_WR:
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_next   = bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == BIT_LAST)
                    begin
                        fwd   = ~gc_reg;
                        flush = gc_reg & (shift_reg == CMD_FLUSH);
                        if (gc_reg && shift_reg == CMD_DATA_AVAIL)
                            pend_next = 1'b1;
                        oe_next    = byte_ok;
                        state_next = byte_ok ? D_WACK : D_IDLE;
                    end
                D_WACK:
                    if (scl_fall)
                    begin
                        oe_next    = 1'b0;
                        bit_next   = 4'h0;
                        state_next = D_WR;
                    end
                D_RD:
                    if (scl_fall)
                    begin
                        if (bit_reg == BIT_DATA_LAST)
                        begin
                            oe_next    = 1'b0;
                            state_next = D_RACK;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                            bit_next   = bit_reg + 4'h1;
                        end
                    end
                D_RACK:
                    if (scl_rise && sda_s)
                        state_next = D_IDLE;
                    else if (scl_fall)
                        load = 1'b1;
                default: state_next = D_IDLE;
            endcase
        end
        if (load)
        begin
            shift_next = rd_byte;
            oe_next    = ~rd_byte[7];
            bit_next   = 4'h0;
            pend_next  = 1'b0;
            pop        = ~pend_reg & ~buf_empty;
            state_next = D_RD;
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= D_IDLE;
            shift_reg <= 8'h00;
            bit_reg   <= 4'h0;
            rw_reg    <= 1'b0;
            gc_reg    <= 1'b0;
            pend_reg  <= 1'b0;
            oe_reg    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_reg   <= bit_next;
            rw_reg    <= rw_next;
            gc_reg    <= gc_next;
            pend_reg  <= pend_next;
            oe_reg    <= oe_next;
        end
    end

    // Link-domain synchronisers and crossings
    always_ff @(posedge link.link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg      <= 5'h1B;
            s2_reg      <= 5'h1B;
            prev_reg    <= 3'h6;
            rx_ack_reg  <= 1'b0;
            tx_tog_reg  <= 1'b0;
            tx_data_reg <= 8'h00;
        end
        else
        begin
            s1_reg   <= {link.scl, link.sda, rx_req_reg, usb_attached,
                         keep_awake_n};
            s2_reg   <= s1_reg;
            prev_reg <= {s2_reg[4], s2_reg[3], s2_reg[2]};
            if (push)
                rx_ack_reg <= ~rx_ack_reg;
            if (fwd)
            begin
                tx_tog_reg  <= ~tx_tog_reg;
                tx_data_reg <= shift_reg;
            end
        end
    end

    // Host-to-link buffer
    always_ff @(posedge link.link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= CNT_RST;
        end
        else
        begin
            wp_reg  <= wp_w + BUF_AW'(push);
            rp_reg  <= flush ? '0 : rp_reg + BUF_AW'(pop);
            cnt_reg <= flush ? 5'(push) : cnt_reg + 5'(push) - 5'(pop);
        end
    end

    always_ff @(posedge link.link_clk)
    begin
        if (push)
            mem[wp_w] <= rx_data_reg;
    end

    // Host-domain side of the crossings
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_req_reg   <= 1'b0;
            rx_data_reg  <= 8'h00;
            rx_ready_reg <= 1'b0;
            m1_reg       <= 3'h1;
            m2_reg       <= 3'h1;
            m_prev_reg   <= 1'b0;
            tx_valid_reg <= 1'b0;
            tx_out_reg   <= 8'h00;
            susp_reg     <= 1'b0;
        end
        else
        begin
            m1_reg     <= {rx_ack_reg, tx_tog_reg, keep_awake_n};
            m2_reg     <= m1_reg;
            m_prev_reg <= m2_reg[1];
            if (usb_rx_valid && rx_ready_reg)
            begin
                rx_data_reg  <= usb_rx_data;
                rx_req_reg   <= ~rx_req_reg;
                rx_ready_reg <= 1'b0;
            end
            else
                rx_ready_reg <= m2_reg[2] == rx_req_reg;
            tx_valid_reg <= m2_reg[1] != m_prev_reg;
            if (m2_reg[1] != m_prev_reg)
                tx_out_reg <= tx_data_reg;
            susp_reg <= ~usb_attached & m2_reg[0];
        end
    end
endmodule // uib_dev_end

// ### design/uib_ctl_end.sv
`timescale 1ns/1ps
module uib_ctl_end #(
    parameter logic [6:0] TARGET_ADDR = uib_pkg::DEFAULT_ADDR
) (
    // Link side
    uib_link_if.controller link,
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Byte commands
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_start,
    input  wire logic       cmd_stop,
    input  wire logic       cmd_read,
    input  wire logic       cmd_nack,
    input  wire logic [7:0] cmd_data,
    // Byte results
    output logic            resp_valid,
    output logic [7:0]      resp_data,
    output logic            resp_ack
);
    import uib_pkg::*;

    uib_cstate_e  state_reg;
    logic [7:0]   qcnt_reg;
    logic [1:0]   q_reg;
    logic [3:0]   bit_reg;
    logic [8:0]   tx_reg;
    logic [8:0]   rx_reg;
    logic         stop_reg;
    logic         rd_reg;
    logic         held_reg;
    logic         ready_reg;
    logic         rv_reg;
    logic [7:0]   rdata_reg;
    logic         rack_reg;
    logic         scl_oe_reg;
    logic         sda_oe_reg;
    logic [1:0]   s1_reg;
    logic [1:0]   s2_reg;
    logic         gc_reg;
    logic         query_reg;
    logic [7:0]   avail_reg;

    // Quarter-bit timing and pin levels per segment
    wire tick      = qcnt_reg == QTR_LAST;
    wire q_end     = tick & (q_reg == 2'h3);
    wire scl_low_w = (state_reg == C_IDLE) ? held_reg
                   : (state_reg == C_STOP) ? (q_reg == 2'h0)
                   : (q_reg == 2'h0) | (q_reg == 2'h3);
    wire sda_low_w = (state_reg == C_START) ? q_reg[1]
                   : (state_reg == C_STOP) ? ~q_reg[1]
                   : (state_reg == C_BITS) & ~tx_reg[8];

    // Command acceptance and the read guard
    wire accept    = cmd_valid & ready_reg;
    wire own_rd    = cmd_start & ~cmd_read & (cmd_data == {TARGET_ADDR, 1'b1});
    wire refuse    = own_rd & ~query_reg & (avail_reg == 8'h00);
    wire byte_done = (state_reg == C_BITS) & q_end & (bit_reg == BIT_LAST);
    wire done      = (byte_done & ~stop_reg) | ((state_reg == C_STOP) & q_end);

    assign link.ctl_scl_o  = 1'b0;
    assign link.ctl_sda_o  = 1'b0;
    assign link.ctl_scl_oe = scl_oe_reg;
    assign link.ctl_sda_oe = sda_oe_reg;
    assign cmd_ready       = ready_reg;
    assign resp_valid      = rv_reg;
    assign resp_data       = rdata_reg;
    assign resp_ack        = rack_reg;

    // Bit-level sequencer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= C_IDLE;
            qcnt_reg  <= 8'h00;
            q_reg     <= 2'h0;
            bit_reg   <= 4'h0;
            tx_reg    <= 9'h1FF;
            rx_reg    <= 9'h000;
            stop_reg  <= 1'b0;
            rd_reg    <= 1'b0;
            held_reg  <= 1'b0;
        end
        else
        begin
            qcnt_reg <= (tick || state_reg == C_IDLE) ? 8'h00
                        : qcnt_reg + 8'h01;
            if (tick)
                q_reg <= q_reg + 2'h1;
            unique case (state_reg)
                C_IDLE:
                    if (accept && !refuse)
                    begin
                        q_reg     <= 2'h0;
                        bit_reg   <= 4'h0;
                        stop_reg  <= cmd_stop;
                        rd_reg    <= cmd_read;
                        tx_reg    <= cmd_read ? {8'hFF, cmd_nack}
                                             : {cmd_data, 1'b1};
                        state_reg <= cmd_start ? C_START : C_BITS;
                    end
                C_START:
                    if (q_end)
                    begin
                        held_reg  <= 1'b1;
                        state_reg <= C_BITS;
                    end
                C_BITS:
                begin
                    if (tick && q_reg == 2'h2)
                        rx_reg <= {rx_reg[7:0], s2_reg[0]};
                    if (q_end)
                    begin
                        tx_reg  <= {tx_reg[7:0], 1'b1};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (byte_done)
                        state_reg <= stop_reg ? C_STOP : C_IDLE;
                end
                C_STOP:
                    if (q_end)
                    begin
                        held_reg  <= 1'b0;
                        state_reg <= C_IDLE;
                    end
            endcase
        end
    end

    // Pins, results and count tracking
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_reg  <= 1'b0;
            rv_reg     <= 1'b0;
            rdata_reg  <= 8'h00;
            rack_reg   <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            s1_reg     <= 2'h3;
            s2_reg     <= 2'h3;
            gc_reg     <= 1'b0;
            query_reg  <= 1'b0;
            avail_reg  <= 8'h00;
        end
        else
        begin
            s1_reg     <= {link.scl, link.sda};
            s2_reg     <= s1_reg;
            scl_oe_reg <= scl_low_w;
            sda_oe_reg <= sda_low_w;
            ready_reg  <= (state_reg == C_IDLE) & ~accept & ~rv_reg;
            rv_reg     <= (accept & refuse) | done;
            if (accept && refuse)
            begin
                rdata_reg <= 8'h00;
                rack_reg  <= 1'b0;
            end
            else if (done)
            begin
                rdata_reg <= rx_reg[8:1];
                rack_reg  <= ~rx_reg[0] | rd_reg;
            end
            if (accept && !refuse && !cmd_read)
            begin
                if (cmd_start)
                    gc_reg <= cmd_data == {GC_ADDR, 1'b0};
                else if (gc_reg && cmd_data == CMD_DATA_AVAIL)
                    query_reg <= 1'b1;
                else if (gc_reg && cmd_data == CMD_FLUSH)
                    avail_reg <= 8'h00;
            end
            if (done && rd_reg)
            begin
                if (query_reg)
                begin
                    avail_reg <= rx_reg[8:1];
                    query_reg <= 1'b0;
                end
                else if (avail_reg != 8'h00)
                    avail_reg <= avail_reg - 8'h01;
            end
        end
    end
endmodule // uib_ctl_end

// ### verif/uib_link_sva.sv
`timescale 1ns/1ps
module uib_link_sva (
    // Clock and reset
    input logic link_clk,
    input logic rst_n,
    // Wire levels and drivers
    input logic scl,
    input logic sda,
    input logic ctl_scl_o,
    input logic ctl_sda_o,
    input logic ctl_sda_oe,
    input logic dev_sda_o,
    input logic dev_sda_oe
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!rst_n);
    dev_od_a: assert property (!dev_sda_o)
        else $error("device drives sda high");
    ctl_od_a: assert property (!ctl_scl_o && !ctl_sda_o)
        else $error("controller drives high");
    dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device sda moved with scl high");
    ack_hold_a: assert property ($rose(dev_sda_oe) |=> dev_sda_oe[*8])
        else $error("device low too short");
    start_ctl_a: assert property ($fell(sda) && scl |-> ctl_sda_oe)
        else $error("start not by controller");
    scl_hi_a: assert property ($rose(scl) |=> scl[*8])
        else $error("scl high too short");
    scl_lo_a: assert property ($fell(scl) |=> !scl[*8])
        else $error("scl low too short");
    stop_quiet_a: assert property ($rose(sda) && scl |=> !dev_sda_oe[*8])
        else $error("device drives after stop");
    cover property ($rose(dev_sda_oe));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule // uib_link_sva

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    import uib_pkg::*;
    localparam logic [7:0] ACK = 8'h01;
    localparam logic [7:0] NAK = 8'h00;
    logic       mclk = 0;
    logic       link_clk = 0;
    logic       rst_n = 0;
    logic [7:0] rx_d = 0;
    logic       rx_v = 0;
    logic       rx_rdy, tx_v, susp, crdy, rv, ra;
    logic [7:0] tx_d, rd, b;
    logic       att = 1;
    logic       ka_n = 1;
    logic       cv = 0, cs = 0, cp = 0, cr = 0, cn = 0;
    logic [7:0] cd = 0;
    logic [7:0] ab [3] = '{{DEFAULT_ADDR ^ 7'h01, 1'b0},
                           {GC_ADDR, 1'b1}, {DEFAULT_ADDR, 1'b0}};
    int         failures = 0, compares = 0, seed = 32'hE8BA4B7E;
    int         bq[$], tq[$];
    always #50 mclk = ~mclk;
    always #3 link_clk = ~link_clk;
    uib_link_if link_if (.link_clk(link_clk));
    uib_dev_end u_uib_dev_end (.link(link_if.device), .mclk(mclk),
        .rst_n(rst_n), .usb_rx_data(rx_d), .usb_rx_valid(rx_v),
        .usb_rx_ready(rx_rdy), .usb_tx_data(tx_d), .usb_tx_valid(tx_v),
        .usb_attached(att), .keep_awake_n(ka_n), .suspended(susp));
    uib_ctl_end u_uib_ctl_end (.link(link_if.controller), .mclk(mclk),
        .rst_n(rst_n), .cmd_valid(cv), .cmd_ready(crdy), .cmd_start(cs),
        .cmd_stop(cp), .cmd_read(cr), .cmd_nack(cn), .cmd_data(cd),
        .resp_valid(rv), .resp_data(rd), .resp_ack(ra));
    uib_link_sva u_sva (.link_clk(link_clk), .rst_n(rst_n),
        .scl(link_if.scl), .sda(link_if.sda),
        .ctl_scl_o(link_if.ctl_scl_o), .ctl_sda_o(link_if.ctl_sda_o),
        .ctl_sda_oe(link_if.ctl_sda_oe), .dev_sda_o(link_if.dev_sda_o),
        .dev_sda_oe(link_if.dev_sda_oe));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(bit s, p, r, n, logic [7:0] d, logic [7:0] e);
        int i = 0;
        @(negedge mclk);
        {cv, cs, cp, cr, cn, cd} = {1'b1, s, p, r, n, d};
        while (crdy !== 1'b1 && ++i < 9000) @(negedge mclk);
        @(posedge mclk);
        @(negedge mclk);
        cv = 0;
        while (rv !== 1'b1 && i++ < 9000) @(negedge mclk);
        chk(r ? rd : {7'h0, ra}, e);
    endtask
    task automatic push(logic [7:0] v);
        int i = 0;
        @(negedge mclk);
        {rx_v, rx_d} = {1'b1, v};
        while (rx_rdy !== 1'b1 && ++i < 99) @(negedge mclk);
        @(posedge mclk);
        @(negedge mclk);
        rx_v = 0;
        bq.push_back(v);
    endtask
    task automatic query();
        xfer(1, 0, 0, 0, {GC_ADDR, 1'b0}, ACK);
        xfer(0, 0, 0, 0, CMD_DATA_AVAIL, ACK);
        xfer(1, 0, 0, 0, {DEFAULT_ADDR, 1'b1}, ACK);
        xfer(0, 1, 1, 1, 0, 8'(bq.size()));
    endtask
    task automatic rd_n(int n);
        xfer(1, 0, 0, 0, {DEFAULT_ADDR, 1'b1}, ACK);
        for (int k = 1; k <= n; k++)
            xfer(0, k == n, 1, k == n, 0, 8'(bq.pop_front()));
    endtask
    task automatic wr(logic [7:0] v);
        xfer(1, 0, 0, 0, {DEFAULT_ADDR, 1'b0}, ACK);
        tq.push_back(v);
        xfer(0, 1, 0, 0, v, ACK);
    endtask
    always @(negedge mclk)
        if (tx_v === 1'b1)
            chk(tx_d, 8'(tq.pop_front()));
    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #10_000_000;
        failures++;
        final_report();
    end
    initial
    begin
        repeat (6) @(negedge mclk);
        rst_n = 1;
        repeat (3) push(rnd());
        query();
        rd_n(2);
        b = 8'(bq[0]);
        rd_n(1);
        wr(b);
        query();
        xfer(1, 1, 0, 0, {DEFAULT_ADDR, 1'b1}, NAK);
        $display("data test done");
        repeat (2) push(rnd());
        xfer(1, 0, 0, 0, {GC_ADDR, 1'b0}, ACK);
        xfer(0, 1, 0, 0, CMD_FLUSH, ACK);
        bq.delete();
        query();
        $display("flush test done");
        foreach (ab[k])
            xfer(1, 1, 0, 0, ab[k], 8'(ab[k] == {DEFAULT_ADDR, 1'b0}));
        repeat (3) wr(rnd());
        $display("address test done");
        for (int k = 0; k < 4; k++)
        begin
            @(negedge mclk);
            {att, ka_n} = 2'(k);
            repeat (4) @(negedge mclk);
            chk({7'h0, susp}, {7'h0, !att && ka_n});
            xfer(1, 0, 0, 0, {GC_ADDR, 1'b0}, ACK);
            xfer(0, 1, 0, 0, CMD_NV_ADDR, {7'h0, att || !ka_n});
        end
        $display("power test done");
        chk(8'(tq.size()), NAK);
        final_report();
    end
endmodule // tb
